// *** inc/ppg_regs.svh ***
// Register offsets, field positions, reset values and timing figures
`ifndef PPG_REGS_SVH
`define PPG_REGS_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PPG_CLK_MHZ 125
`define PPG_F_LO_KHZ 250
`define PPG_F_HI_KHZ 600
`define PPG_SPREAD_PCT 4
`define PPG_MOD_DIV_LO 12
`define PPG_MOD_DIV_HI 28
`define PPG_WDOG_US 20
`define PPG_WDOG_W 12

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define PPG_CTRL_OFS 8'h00
`define PPG_STATUS_OFS 8'h04
`define PPG_IRQ_STAT_OFS 8'h08
`define PPG_IRQ_MASK_OFS 8'h0C

// ----------------------------------------------------------------
// Fields
// ----------------------------------------------------------------
`define PPG_CTRL_SOFT_DIS 0
`define PPG_CTRL_FORCE_INT 1
`define PPG_ST_RUNNING 0
`define PPG_ST_EXT_MODE 1
`define PPG_ST_OVER_CUR 2
`define PPG_ST_OVER_TEMP 3
`define PPG_ST_PHASE 4
`define PPG_ST_FAULT 5
`define PPG_IRQ_FAULT 0
`define PPG_IRQ_EXT_LOST 1
`define PPG_IRQ_EXT_GAIN 2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PPG_CTRL_RST 2'h0
`define PPG_IRQ_MASK_RST 3'h0

`endif

// *** inc/ppg_pkg.sv ***
// Types shared by the phase generator design files
package ppg_pkg;

    // ------------------------------------------------------------
    // Switching source
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        PPG_OFF = 3'b001,
        PPG_INT = 3'b010,
        PPG_EXT = 3'b100
    } ppg_mode_t;

    // ------------------------------------------------------------
    // Pin inputs as one group
    // ------------------------------------------------------------
    typedef struct packed {
        logic ext_clk;
        logic enable_n;
        logic high_freq;
        logic spread;
        logic over_cur;
        logic over_temp;
    } ppg_pins_t;

    // ------------------------------------------------------------
    // State of the top module
    // ------------------------------------------------------------
    typedef struct packed {
        ppg_pins_t meta;
        ppg_pins_t sync;
        logic prev_clk;
        logic [11:0] wdog;
        logic ext_live;
        ppg_mode_t mode;
        logic phase;
        logic fault;
        logic [1:0] ctrl;
        logic [2:0] irq_stat;
        logic [2:0] irq_mask;
        logic bus_pend;
        logic bus_wr;
        logic bus_hit;
        logic [7:0] bus_ofs;
        logic rd_ready;
        logic [31:0] rdata;
    } ppg_state_t;

    // ------------------------------------------------------------
    // State of the internal oscillator
    // ------------------------------------------------------------
    typedef struct packed {
        logic [9:0] cnt;
        logic signed [6:0] off;
        logic up;
        logic [7:0] acc;
        logic toggle;
    } ppg_osc_state_t;

endpackage : ppg_pkg

// *** verilog/ppg_osc.sv ***
// Internal oscillator with selectable rate and triangular spread
`timescale 1ns/100ps
`default_nettype none

module ppg_osc #(
    parameter int HALF_LO = 250,
    parameter int HALF_HI = 104,
    parameter int DEV_LO = 10,
    parameter int DEV_HI = 4,
    parameter int MOD_LO = 12,
    parameter int MOD_HI = 28
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic run_i,
    input wire logic high_freq_i,
    input wire logic spread_i,
    output logic toggle_o
);

    ppg_pkg::ppg_osc_state_t s_q;
    ppg_pkg::ppg_osc_state_t s_d;

    always_comb begin
        logic [9:0] base;
        logic signed [6:0] dev;
        logic [7:0] step;
        logic [7:0] den;
        logic [8:0] acc_n;
        logic [10:0] target;
        logic [1:0] moves;
        s_d = s_q;
        base = high_freq_i ? 10'(HALF_HI) : 10'(HALF_LO);
        dev = high_freq_i ? 7'(DEV_HI) : 7'(DEV_LO);
        step = high_freq_i ? 8'(4 * DEV_HI) : 8'(4 * DEV_LO);
        den = high_freq_i ? 8'(2 * MOD_HI) : 8'(2 * MOD_LO);
        acc_n = {1'b0, s_q.acc} + {1'b0, step};
        moves = 2'd0;
        target = 11'($signed({1'b0, base}) + s_q.off);
        s_d.toggle = 1'b0;
        if (!run_i) begin
            s_d.cnt = 10'h000;
        end else if ({1'b0, s_q.cnt} + 11'h001 >= target) begin
            // Half period over: flip the phase and move the spread offset
            s_d.cnt = 10'h000;
            s_d.toggle = 1'b1;
            if (spread_i) begin
                if (acc_n >= {1'b0, den}) begin
                    acc_n = acc_n - {1'b0, den};
                    moves = 2'd1;
                end
                if (acc_n >= {1'b0, den}) begin
                    acc_n = acc_n - {1'b0, den};
                    moves = 2'd2;
                end
                s_d.acc = acc_n[7:0];
                for (int i = 0; i < 2; i++) begin
                    if (2'(i) < moves) begin
                        if (s_d.up && s_d.off >= dev) begin
                            s_d.up = 1'b0;
                        end else if (!s_d.up && s_d.off <= -dev) begin
                            s_d.up = 1'b1;
                        end
                        s_d.off = s_d.up ? s_d.off + 7'sd1 : s_d.off - 7'sd1;
                    end
                end
            end
        end else begin
            s_d.cnt = s_q.cnt + 10'h001;
        end
        if (!spread_i) begin
            // Fixed rate when spread is off
            s_d.off = 7'sd0;
            s_d.acc = 8'h00;
            s_d.up = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_q <= '{cnt: 10'h000, off: 7'sd0, up: 1'b1, acc: 8'h00,
                     toggle: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign toggle_o = s_q.toggle;

endmodule : ppg_osc

`default_nettype wire

// *** verilog/ppg_top.sv ***
// Push-pull phase generator with AHB-Lite register slave
`timescale 1ns/100ps
`default_nettype none
`include "ppg_regs.svh"

// Notes on behaviour
// - The block runs only while the enable pin is low; high disables it.
// - Spread select high modulates the internal rate by plus or minus 4%.
// - Spread select is ignored while the external clock drives switching.
// - Fault pulls low on overcurrent or overtemperature.
// - Frequency select high gives 600kHz switching, low gives 250kHz.
// - A clock pin held at ground keeps the internal oscillator in use.
// - A toggling clock pin selects external clocking by itself.
// - External clock is divided by two by a toggle stage, 50% duty.
// - In external mode the drives change only on clock pin rising edges.
// - With spread off the internal oscillator yields 50% duty with equal phase on-times.
// - No clock pin edge for at least 20us returns to the internal source.
// - While disabled both drives are high impedance.
// - Fault stays asserted while the condition lasts, then releases.
module ppg_top #(
    parameter int WDOG_CYCLES = `PPG_WDOG_US * `PPG_CLK_MHZ
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic hreadyout_o,
    output logic [31:0] hrdata_o,
    output logic hresp_o,
    input wire logic ext_clk_i,
    input wire logic enable_n_i,
    input wire logic high_freq_select_i,
    input wire logic spread_select_i,
    input wire logic over_cur_i,
    input wire logic over_temp_i,
    output logic drive_out_a_o,
    output logic drive_out_a_oe_n_o,
    output logic drive_out_b_o,
    output logic drive_out_b_oe_n_o,
    output logic fault_n_o,
    output logic fault_oe_n_o,
    output logic irq_o
);

    // ------------------------------------------------------------
    // Derived timing
    // ------------------------------------------------------------
    localparam int HALF_LO = `PPG_CLK_MHZ * 1000 / (2 * `PPG_F_LO_KHZ);
    localparam int HALF_HI = `PPG_CLK_MHZ * 1000 / (2 * `PPG_F_HI_KHZ);
    localparam int DEV_LO = HALF_LO * `PPG_SPREAD_PCT / 100;
    localparam int DEV_HI = HALF_HI * `PPG_SPREAD_PCT / 100;
    localparam logic [11:0] WDOG_LIM = 12'(WDOG_CYCLES);

    ppg_pkg::ppg_state_t s_q;
    ppg_pkg::ppg_state_t s_d;
    ppg_pkg::ppg_pins_t pins_raw;
    logic osc_toggle;
    logic osc_run;
    logic osc_spread;

    assign pins_raw = '{ext_clk: ext_clk_i, enable_n: enable_n_i,
                        high_freq: high_freq_select_i,
                        spread: spread_select_i, over_cur: over_cur_i,
                        over_temp: over_temp_i};

    // ------------------------------------------------------------
    // Internal oscillator
    // ------------------------------------------------------------
    assign osc_run = (s_q.mode == ppg_pkg::PPG_INT);
    assign osc_spread = s_q.sync.spread & osc_run;

    ppg_osc #(
        .HALF_LO(HALF_LO),
        .HALF_HI(HALF_HI),
        .DEV_LO(DEV_LO),
        .DEV_HI(DEV_HI),
        .MOD_LO(`PPG_MOD_DIV_LO),
        .MOD_HI(`PPG_MOD_DIV_HI)
    ) u_osc (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .run_i(osc_run),
        .high_freq_i(s_q.sync.high_freq),
        .spread_i(osc_spread),
        .toggle_o(osc_toggle)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic clk_rise;
        logic clk_edge;
        logic enabled;
        logic accept;
        logic [2:0] ev;
        logic [2:0] clr;
        logic [31:0] rd;
        s_d = s_q;
        ev = 3'h0;
        clr = 3'h0;
        rd = 32'h0000_0000;

        // Pins pass two flops before use
        s_d.meta = pins_raw;
        s_d.sync = s_q.meta;
        s_d.prev_clk = s_q.sync.ext_clk;
        clk_rise = s_q.sync.ext_clk & ~s_q.prev_clk;
        clk_edge = s_q.sync.ext_clk ^ s_q.prev_clk;

        // Clock pin activity watchdog
        if (clk_edge) begin
            s_d.wdog = 12'h000;
            s_d.ext_live = 1'b1;
        end else if (s_q.wdog < WDOG_LIM) begin
            s_d.wdog = s_q.wdog + 12'h001;
        end else begin
            s_d.ext_live = 1'b0;
        end

        enabled = ~s_q.sync.enable_n
                  & ~s_q.ctrl[`PPG_CTRL_SOFT_DIS]
                  & ~s_q.sync.over_temp;

        // Source selection
        unique case (s_q.mode)
            ppg_pkg::PPG_OFF: begin
                if (enabled) begin
                    s_d.mode = ppg_pkg::PPG_INT;
                end
            end
            ppg_pkg::PPG_INT: begin
                if (!enabled) begin
                    s_d.mode = ppg_pkg::PPG_OFF;
                end else if (s_q.ext_live && clk_rise
                             && !s_q.ctrl[`PPG_CTRL_FORCE_INT]) begin
                    s_d.mode = ppg_pkg::PPG_EXT;
                    ev[`PPG_IRQ_EXT_GAIN] = 1'b1;
                end
            end
            ppg_pkg::PPG_EXT: begin
                if (!enabled) begin
                    s_d.mode = ppg_pkg::PPG_OFF;
                end else if (!s_q.ext_live
                             || s_q.ctrl[`PPG_CTRL_FORCE_INT]) begin
                    s_d.mode = ppg_pkg::PPG_INT;
                    ev[`PPG_IRQ_EXT_LOST] = 1'b1;
                end
            end
            default: begin
                s_d.mode = ppg_pkg::PPG_OFF;
            end
        endcase

        // Toggle stage shared by both sources
        unique case (s_q.mode)
            ppg_pkg::PPG_INT: begin
                if (osc_toggle) begin
                    s_d.phase = ~s_q.phase;
                end
            end
            ppg_pkg::PPG_EXT: begin
                if (clk_rise) begin
                    s_d.phase = ~s_q.phase;
                end
            end
            default: begin
                s_d.phase = 1'b0;
            end
        endcase

        // Fault follows the condition inputs
        s_d.fault = s_q.sync.over_cur | s_q.sync.over_temp;
        if (s_d.fault && !s_q.fault) begin
            ev[`PPG_IRQ_FAULT] = 1'b1;
        end

        // Bus data phase, then address phase
        accept = hsel_i & htrans_i[1] & hready_i;
        if (s_q.bus_pend && s_q.bus_wr && s_q.bus_hit) begin
            unique case (s_q.bus_ofs)
                `PPG_CTRL_OFS: s_d.ctrl = hwdata_i[1:0];
                `PPG_IRQ_STAT_OFS: clr = hwdata_i[2:0];
                `PPG_IRQ_MASK_OFS: s_d.irq_mask = hwdata_i[2:0];
                default: begin
                end
            endcase
        end
        if (s_q.bus_pend && !s_q.bus_wr && !s_q.rd_ready) begin
            if (s_q.bus_hit) begin
                unique case (s_q.bus_ofs)
                    `PPG_CTRL_OFS: rd[1:0] = s_q.ctrl;
                    `PPG_STATUS_OFS: begin
                        rd[`PPG_ST_RUNNING] = s_q.mode != ppg_pkg::PPG_OFF;
                        rd[`PPG_ST_EXT_MODE] = s_q.mode == ppg_pkg::PPG_EXT;
                        rd[`PPG_ST_OVER_CUR] = s_q.sync.over_cur;
                        rd[`PPG_ST_OVER_TEMP] = s_q.sync.over_temp;
                        rd[`PPG_ST_PHASE] = s_q.phase;
                        rd[`PPG_ST_FAULT] = s_q.fault;
                    end
                    `PPG_IRQ_STAT_OFS: rd[2:0] = s_q.irq_stat;
                    `PPG_IRQ_MASK_OFS: rd[2:0] = s_q.irq_mask;
                    default: begin
                    end
                endcase
            end
            s_d.rdata = rd;
            s_d.rd_ready = 1'b1;
        end
        if (accept) begin
            s_d.bus_pend = 1'b1;
            s_d.bus_wr = hwrite_i;
            s_d.bus_hit = (haddr_i[31:8] == 24'h00_0000)
                          && (haddr_i[1:0] == 2'b00);
            s_d.bus_ofs = haddr_i[7:0];
            s_d.rd_ready = 1'b0;
        end else if (hreadyout_o) begin
            s_d.bus_pend = 1'b0;
        end

        // Sticky events: a new event wins over a clear
        s_d.irq_stat = (s_q.irq_stat & ~clr) | ev;
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_q <= '{meta: 6'b010000, sync: 6'b010000, prev_clk: 1'b0,
                     wdog: 12'h000, ext_live: 1'b0,
                     mode: ppg_pkg::PPG_OFF, phase: 1'b0, fault: 1'b0,
                     ctrl: `PPG_CTRL_RST, irq_stat: 3'h0,
                     irq_mask: `PPG_IRQ_MASK_RST, bus_pend: 1'b0,
                     bus_wr: 1'b0, bus_hit: 1'b0, bus_ofs: 8'h00,
                     rd_ready: 1'b0, rdata: 32'h0000_0000};
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign drive_out_a_o = s_q.phase;
    assign drive_out_b_o = ~s_q.phase;
    assign drive_out_a_oe_n_o = (s_q.mode == ppg_pkg::PPG_OFF);
    assign drive_out_b_oe_n_o = (s_q.mode == ppg_pkg::PPG_OFF);
    assign fault_n_o = 1'b0;
    assign fault_oe_n_o = ~s_q.fault;
    assign irq_o = |(s_q.irq_stat & s_q.irq_mask);
    assign hreadyout_o = ~(s_q.bus_pend & ~s_q.bus_wr & ~s_q.rd_ready);
    assign hrdata_o = s_q.rdata;
    assign hresp_o = 1'b0;

endmodule : ppg_top

`default_nettype wire

// *** sim/ppg_sva.sv ***
// Checker for the phase generator pins and bus handshake
`timescale 1ns/100ps
`default_nettype none

module ppg_sva #(
    parameter int WDOG_CYCLES = 2500
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic hsel_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic hready_i,
    input wire logic hreadyout_o,
    input wire logic hresp_o,
    input wire logic ext_clk_i,
    input wire logic enable_n_i,
    input wire logic over_cur_i,
    input wire logic over_temp_i,
    input wire logic drive_out_a_o,
    input wire logic drive_out_a_oe_n_o,
    input wire logic drive_out_b_o,
    input wire logic drive_out_b_oe_n_o,
    input wire logic fault_n_o,
    input wire logic fault_oe_n_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    // ------------------------------------------------------------
    // Ages of the last clock pin edges
    // ------------------------------------------------------------
    logic ext_q;
    int rise_age_q;
    int edge_age_q;
    logic armed_q;
    logic prior_q;

    // Armed well after a rise that follows a recent edge: source is external
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ext_q <= 1'b0;
            rise_age_q <= 4095;
            edge_age_q <= 4095;
            armed_q <= 1'b0;
            prior_q <= 1'b0;
        end else begin
            ext_q <= ext_clk_i;
            if (ext_clk_i && !ext_q) begin
                rise_age_q <= 0;
                prior_q <= edge_age_q < WDOG_CYCLES - 8;
            end else if (rise_age_q < 4095) begin
                rise_age_q <= rise_age_q + 1;
            end
            if (ext_clk_i != ext_q) begin
                edge_age_q <= 0;
            end else if (edge_age_q < 4095) begin
                edge_age_q <= edge_age_q + 1;
            end
            if (edge_age_q >= WDOG_CYCLES - 8) begin
                armed_q <= 1'b0;
            end else if (rise_age_q == 12 && prior_q) begin
                armed_q <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    property p_comp;
        drive_out_b_o != drive_out_a_o;
    endproperty
    a_comp: assert property (p_comp)
        else $error("drive phases not complementary");

    property p_oe_pair;
        drive_out_b_oe_n_o == drive_out_a_oe_n_o;
    endproperty
    a_oe_pair: assert property (p_oe_pair)
        else $error("drive enables differ");

    property p_off;
        enable_n_i [*4] |-> drive_out_a_oe_n_o;
    endproperty
    a_off: assert property (p_off)
        else $error("drives not released while disabled");

    property p_on;
        (!enable_n_i && !over_temp_i) [*4] |-> !drive_out_a_oe_n_o;
    endproperty
    a_on: assert property (p_on)
        else $error("drives not driven while enabled");

    property p_flt_on;
        (over_cur_i || over_temp_i) [*4] |-> !fault_oe_n_o && !fault_n_o;
    endproperty
    a_flt_on: assert property (p_flt_on)
        else $error("fault not asserted");

    property p_flt_off;
        !(over_cur_i || over_temp_i) [*4] |-> fault_oe_n_o;
    endproperty
    a_flt_off: assert property (p_flt_off)
        else $error("fault not released");

    property p_ext_edge;
        $changed(drive_out_a_o) && armed_q && !drive_out_a_oe_n_o
            && !$past(drive_out_a_oe_n_o) |-> rise_age_q inside {[2:5]};
    endproperty
    a_ext_edge: assert property (p_ext_edge)
        else $error("drive changed away from a clock pin rise");

    property p_rd;
        hsel_i && htrans_i[1] && hready_i && !hwrite_i
            |=> !hreadyout_o ##1 hreadyout_o;
    endproperty
    a_rd: assert property (p_rd)
        else $error("read wait state wrong");

    property p_okay;
        !hresp_o;
    endproperty
    a_okay: assert property (p_okay)
        else $error("response not okay");

    c_ext: cover property (armed_q && $changed(drive_out_a_o));
    c_fault: cover property (!fault_oe_n_o);
    c_off: cover property ($rose(drive_out_a_oe_n_o));
endmodule : ppg_sva

bind ppg_top ppg_sva #(.WDOG_CYCLES(WDOG_CYCLES)) u_sva (
    .clk_i(clk_i), .rstn_i(rstn_i), .hsel_i(hsel_i), .htrans_i(htrans_i),
    .hwrite_i(hwrite_i), .hready_i(hready_i), .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o), .ext_clk_i(ext_clk_i), .enable_n_i(enable_n_i),
    .over_cur_i(over_cur_i), .over_temp_i(over_temp_i),
    .drive_out_a_o(drive_out_a_o), .drive_out_a_oe_n_o(drive_out_a_oe_n_o),
    .drive_out_b_o(drive_out_b_o), .drive_out_b_oe_n_o(drive_out_b_oe_n_o),
    .fault_n_o(fault_n_o), .fault_oe_n_o(fault_oe_n_o)
);
`default_nettype wire

// *** sim/ppg_xfmr.sv ***
// Power switch and transformer primary model for the phase generator
`timescale 1ns/100ps
`default_nettype none

module ppg_xfmr (
    input wire logic clk_i,
    input wire logic on_a_i,
    input wire logic oe_a_n_i,
    input wire logic on_b_i,
    input wire logic oe_b_n_i,
    input wire logic fault_n_i,
    input wire logic fault_oe_n_i,
    output logic fault_line_o,
    output int overlap_o
);
    // Pulled-up fault line, low only while the open drain sinks it
    assign fault_line_o = fault_oe_n_i ? 1'b1 : fault_n_i;

    initial overlap_o = 0;

    // Both halves conducting at once shorts the primary
    always @(posedge clk_i) begin
        if (!oe_a_n_i && !oe_b_n_i && on_a_i && on_b_i) begin
            overlap_o <= overlap_o + 1;
        end
    end
endmodule : ppg_xfmr
`default_nettype wire

// *** sim/tb.sv ***
// Self-checking bench for the push-pull phase generator
`timescale 1ns/100ps
`default_nettype none
`include "ppg_regs.svh"

module tb;
    localparam int WDOG = 200;
    localparam logic [31:0] H_LO = 32'h0000_00FA;
    localparam logic [31:0] H_HI = 32'h0000_0068;
    localparam logic [31:0] H_EXT = 32'h0000_0040;
    logic clk_i;
    logic rstn_i;
    logic hsel, hwrite, hrdyo, ext_clk, en_n, hf, spr, oc, ot, run_ext;
    logic [31:0] haddr, hwdata, hrdata, v;
    logic [1:0] htrans;
    logic [5:0] div;
    logic a, a_oe_n, b, b_oe_n, f_n, f_oe_n, irq, f_line;
    int ovl, bad_count, cmp_count, c, mn, mx;

    ppg_top #(.WDOG_CYCLES(WDOG)) uut (
        .clk_i(clk_i), .rstn_i(rstn_i), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
        .hwdata_i(hwdata), .hready_i(hrdyo), .hreadyout_o(hrdyo),
        .hrdata_o(hrdata), .hresp_o(), .ext_clk_i(ext_clk),
        .enable_n_i(en_n), .high_freq_select_i(hf), .spread_select_i(spr),
        .over_cur_i(oc), .over_temp_i(ot), .drive_out_a_o(a),
        .drive_out_a_oe_n_o(a_oe_n), .drive_out_b_o(b),
        .drive_out_b_oe_n_o(b_oe_n), .fault_n_o(f_n),
        .fault_oe_n_o(f_oe_n), .irq_o(irq)
    );

    ppg_xfmr load (
        .clk_i(clk_i), .on_a_i(a), .oe_a_n_i(a_oe_n), .on_b_i(b),
        .oe_b_n_i(b_oe_n), .fault_n_i(f_n), .fault_oe_n_i(f_oe_n),
        .fault_line_o(f_line), .overlap_o(ovl)
    );

    always #4 clk_i = ~clk_i;

    // External clock of 64 cycles, held at ground while stopped
    always @(posedge clk_i) begin
        div <= div + 6'h1;
        ext_clk <= run_ext & div[5];
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic bit_chk(input logic seen, input logic exp);
        check({31'h0, seen}, {31'h0, exp});
    endtask : bit_chk

    task automatic give_up;
        bad_count++;
        tally_and_finish();
    endtask : give_up

    task automatic wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (hrdyo !== 1'b1 && n < 50);
        if (n >= 50) give_up();
    endtask : wait_rdy

    task automatic bus(input logic wr, input logic [7:0] ad,
                       input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, ad};
        htrans <= 2'h2;
        hwrite <= wr;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        v = hrdata;
    endtask : bus

    task automatic rdchk(input logic [7:0] ad, input logic [31:0] m,
                         input logic [31:0] e);
        bus(1'b0, ad, 32'h0000_0000);
        check(v & m, e);
    endtask : rdchk

    // Cycles until drive A next changes, counted on falling edges
    task automatic flip(output int n);
        logic s;
        s = a;
        n = 0;
        while (a === s && n < 3000) begin
            @(negedge clk_i);
            n++;
        end
        if (n >= 3000) give_up();
    endtask : flip

    task automatic settle(input int k);
        repeat (k) @(posedge clk_i);
        #1;
    endtask : settle

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        clk_i = 0; rstn_i = 0; hsel = 0; haddr = 0; htrans = 0;
        hwrite = 0; hwdata = 0; ext_clk = 0; en_n = 1; hf = 0; spr = 0;
        oc = 0; ot = 0; run_ext = 0; div = 0; bad_count = 0; cmp_count = 0;
        settle(8);
        bit_chk(a_oe_n, 1'b1);
        bit_chk(f_line, 1'b1);
        @(posedge clk_i);
        rstn_i <= 1'b1;
        @(posedge clk_i);
        rdchk(`PPG_CTRL_OFS, 32'hFFFF_FFFF, 32'h0000_0000);
        bus(1'b1, `PPG_CTRL_OFS, 32'h0000_0003);
        rdchk(`PPG_CTRL_OFS, 32'hFFFF_FFFF, 32'h0000_0003);
        bus(1'b1, `PPG_CTRL_OFS, 32'h0000_0000);
        rdchk(`PPG_IRQ_MASK_OFS, 32'hFFFF_FFFF, 32'h0000_0000);
        bus(1'b1, 8'h10, 32'hFFFF_FFFF);
        rdchk(8'h10, 32'hFFFF_FFFF, 32'h0000_0000);
        en_n <= 1'b0;
        settle(4);
        bit_chk(a_oe_n, 1'b0);
        for (int i = 0; i < 2; i++) begin
            @(posedge clk_i);
            hf <= i[0];
            repeat (3) flip(c);
            flip(c);
            check(32'(c), i ? H_HI : H_LO);
            flip(c);
            check(32'(c), i ? H_HI : H_LO);
        end
        @(posedge clk_i);
        hf <= 1'b0;
        spr <= 1'b1;
        repeat (3) flip(c);
        mn = 9999;
        mx = 0;
        repeat (60) begin
            flip(c);
            mn = (c < mn) ? c : mn;
            mx = (c > mx) ? c : mx;
        end
        check(32'(mn >= 240 && mx <= 260), 32'h0000_0001);
        check(32'(mx - mn >= 10), 32'h0000_0001);
        @(posedge clk_i);
        run_ext <= 1'b1;
        repeat (4) flip(c);
        flip(c);
        check(32'(c), H_EXT);
        flip(c);
        check(32'(c), H_EXT);
        @(posedge clk_i);
        rdchk(`PPG_STATUS_OFS, 32'h0000_0002, 32'h0000_0002);
        rdchk(`PPG_IRQ_STAT_OFS, 32'h0000_0004, 32'h0000_0004);
        bus(1'b1, `PPG_IRQ_MASK_OFS, 32'h0000_0004);
        settle(1);
        bit_chk(irq, 1'b1);
        @(posedge clk_i);
        bus(1'b1, `PPG_IRQ_STAT_OFS, 32'h0000_0004);
        settle(1);
        bit_chk(irq, 1'b0);
        @(posedge clk_i);
        bus(1'b1, `PPG_IRQ_MASK_OFS, 32'h0000_0000);
        run_ext <= 1'b0;
        spr <= 1'b0;
        repeat (WDOG - 40) @(posedge clk_i);
        rdchk(`PPG_STATUS_OFS, 32'h0000_0002, 32'h0000_0002);
        repeat (60) @(posedge clk_i);
        rdchk(`PPG_STATUS_OFS, 32'h0000_0002, 32'h0000_0000);
        rdchk(`PPG_IRQ_STAT_OFS, 32'h0000_0002, 32'h0000_0002);
        repeat (2) flip(c);
        check(32'(c), H_LO);
        @(posedge clk_i);
        oc <= 1'b1;
        settle(4);
        bit_chk(f_line, 1'b0);
        @(posedge clk_i);
        oc <= 1'b0;
        settle(4);
        bit_chk(f_line, 1'b1);
        @(posedge clk_i);
        ot <= 1'b1;
        settle(4);
        bit_chk(f_line, 1'b0);
        @(posedge clk_i);
        ot <= 1'b0;
        settle(4);
        bit_chk(f_line, 1'b1);
        @(posedge clk_i);
        rdchk(`PPG_IRQ_STAT_OFS, 32'h0000_0001, 32'h0000_0001);
        en_n <= 1'b1;
        settle(4);
        bit_chk(a_oe_n, 1'b1);
        bit_chk(b_oe_n, 1'b1);
        check(32'(ovl), 32'h0000_0000);
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire
